// ==== src/plps_pkg.sv ====
// package for positioning limit and program select logic
// assumes a single mclk domain, synchronous active-high reset
// Operation
// - homing starts: enable, control holding, go high
// - zero search off: finish on cam only
// - three homing velocities, freely settable
// - signed positive and negative travel limits
// - target outside limits: refuse move, flag error
// - limit reached: brake with ramp, flag error
// - braking ramp unsigned 0 to 65535 rpm/s
// - both limits zero: no limit monitoring
// - no limit monitoring while homing runs
// - coding: fixed, one-hot, binary, BCD
// - fixed coding runs fixed number 0..99
// - one-hot coding: eight inputs, programs 0..7
// - invalid BCD raises program unavailable
// - rising start edge launches selected program
// - factory default starts program zero
package plps_pkg;
	localparam int POS_W = 32;
	localparam int VEL_W = 32;
	localparam int RAMP_W = 16;
	localparam int PROG_W = 7;
	localparam int SEL_W = 8;
	localparam logic [PROG_W-1:0] PROG_MAX = 7'h63;
	localparam logic [PROG_W-1:0] DEFAULT_PROGRAM_ZERO = 7'h00;
	localparam logic [RAMP_W-1:0] RAMP_RESET = 16'h0000;

	typedef enum logic [1:0] {
		CODING_FIXED = 2'b00,
		CODING_ONE_HOT_INPUTS = 2'b01,
		CODING_BINARY_INPUTS = 2'b10,
		CODING_BCD_INPUTS = 2'b11
	} plps_coding_type;

	typedef enum logic [1:0] {
		HOME_IDLE = 2'b00,
		HOME_ENABLED = 2'b01,
		HOME_HOLDING = 2'b10,
		HOME_RUN = 2'b11
	} plps_home_type;

	typedef struct packed {
		logic signed [POS_W-1:0] positive_travel_limit;
		logic signed [POS_W-1:0] negative_travel_limit;
		logic [RAMP_W-1:0] limit_braking_ramp;
	} plps_limit_cfg_type;

	typedef struct packed {
		logic [VEL_W-1:0] first_homing_velocity;
		logic [VEL_W-1:0] second_homing_velocity;
		logic [VEL_W-1:0] third_homing_velocity;
	} plps_home_vel_type;
endpackage : plps_pkg

// ==== src/plps_top.sv ====
// homing gate, software travel limit monitor and program selector
// assumes terminal pins asynchronous, other inputs on mclk
`timescale 1ns/10ps
module plps_top
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset,
	// terminal pins
	input wire logic power_stage_enable_input,
	input wire logic go_input,
	input wire logic start_input,
	input wire logic [plps_pkg::SEL_W-1:0] select_inputs,
	// controller state
	input wire logic control_holding,
	input wire logic cam_found,
	input wire logic zero_pulse,
	input wire logic zero_search_enable,
	// configuration
	input wire plps_pkg::plps_limit_cfg_type limit_cfg,
	input wire plps_pkg::plps_home_vel_type home_vel_cfg,
	input wire plps_pkg::plps_coding_type program_select_coding,
	input wire logic [plps_pkg::PROG_W-1:0] fixed_program_number,
	input wire logic [plps_pkg::PROG_W:0] programs_stored,
	// motion
	input wire logic signed [plps_pkg::POS_W-1:0] actual_position,
	input wire logic signed [plps_pkg::POS_W-1:0] target_position,
	input wire logic move_request,
	// outputs
	output logic homing_active,
	output logic homing_done,
	output plps_pkg::plps_home_vel_type homing_velocity,
	output logic move_accept,
	output logic target_limit_error,
	output logic limit_reached_error,
	output logic brake_active,
	output logic [plps_pkg::RAMP_W-1:0] brake_ramp,
	output logic program_launch,
	output logic [plps_pkg::PROG_W-1:0] program_number,
	output logic program_unavailable_error
);
	import plps_pkg::*;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (reset);

	// pin synchronisers, stage one read only by stage two
	logic [SEL_W+2:0] sync1_r;
	logic [SEL_W+2:0] sync2_r;
	logic start_prev_r;
	logic en_s;
	logic go_s;
	logic start_s;
	logic [SEL_W-1:0] sel_s;
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			start_prev_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {power_stage_enable_input, go_input, start_input,
				select_inputs};
			sync2_r <= sync1_r;
			start_prev_r <= start_s;
		end
	end
	assign {en_s, go_s, start_s, sel_s} = sync2_r;

	// homing sequence
	plps_home_type home_r;
	plps_home_type home_nxt;
	logic done_r;
	logic done_nxt;
	always_comb
	begin
		home_nxt = home_r;
		done_nxt = done_r;
		unique case (home_r)
			HOME_IDLE:
				if (en_s)
					home_nxt = HOME_ENABLED;
			HOME_ENABLED:
				if (!en_s)
					home_nxt = HOME_IDLE;
				else if (control_holding)
					home_nxt = HOME_HOLDING;
			HOME_HOLDING:
				if (!en_s || !control_holding)
					home_nxt = HOME_IDLE;
				else if (go_s)
				begin
					home_nxt = HOME_RUN;
					done_nxt = 1'b0;
				end
			HOME_RUN:
				if (!en_s || !control_holding)
					home_nxt = HOME_IDLE;
				// cam alone ends the run when zero search is off
				else if (cam_found && (!zero_search_enable || zero_pulse))
				begin
					home_nxt = HOME_HOLDING;
					done_nxt = 1'b1;
				end
		endcase
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			home_r <= HOME_IDLE;
			done_r <= 1'b0;
		end
		else
		begin
			home_r <= home_nxt;
			done_r <= done_nxt;
		end
	end
	assign homing_active = (home_r == HOME_RUN);
	assign homing_done = done_r;
	assign homing_velocity = home_vel_cfg;

	// travel limits, relative to machine zero
	logic mon_en;
	logic tgt_out;
	logic at_limit;
	logic accept_r;
	logic accept_nxt;
	logic tgt_err_r;
	logic tgt_err_nxt;
	logic lim_err_r;
	logic lim_err_nxt;
	logic brake_r;
	logic brake_nxt;
	logic [RAMP_W-1:0] ramp_r;
	logic [RAMP_W-1:0] ramp_nxt;
	always_comb
	begin
		mon_en = ((limit_cfg.positive_travel_limit != '0) ||
			(limit_cfg.negative_travel_limit != '0)) &&
			!homing_active;
		tgt_out = (target_position > limit_cfg.positive_travel_limit) ||
			(target_position < limit_cfg.negative_travel_limit);
		at_limit = (actual_position >= limit_cfg.positive_travel_limit) ||
			(actual_position <= limit_cfg.negative_travel_limit);
		accept_nxt = move_request && !(mon_en && tgt_out);
		tgt_err_nxt = tgt_err_r;
		if (move_request)
			tgt_err_nxt = mon_en && tgt_out;
		// braking holds while the axis sits on a limit
		brake_nxt = mon_en && at_limit;
		lim_err_nxt = lim_err_r || brake_nxt;
		if (!mon_en)
			lim_err_nxt = 1'b0;
		ramp_nxt = limit_cfg.limit_braking_ramp;
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			accept_r <= 1'b0;
			tgt_err_r <= 1'b0;
			lim_err_r <= 1'b0;
			brake_r <= 1'b0;
			ramp_r <= RAMP_RESET;
		end
		else
		begin
			accept_r <= accept_nxt;
			tgt_err_r <= tgt_err_nxt;
			lim_err_r <= lim_err_nxt;
			brake_r <= brake_nxt;
			ramp_r <= ramp_nxt;
		end
	end
	assign move_accept = accept_r;
	assign target_limit_error = tgt_err_r;
	assign limit_reached_error = lim_err_r;
	assign brake_active = brake_r;
	assign brake_ramp = ramp_r;

	// program selection decode
	logic start_edge;
	logic [PROG_W-1:0] dec_num;
	logic dec_bad;
	logic [3:0] ones;
	logic [3:0] tens;
	logic launch_r;
	logic launch_nxt;
	logic [PROG_W-1:0] prog_r;
	logic [PROG_W-1:0] prog_nxt;
	logic unav_r;
	logic unav_nxt;
	always_comb
	begin
		start_edge = start_s && !start_prev_r;
		dec_num = DEFAULT_PROGRAM_ZERO;
		dec_bad = 1'b0;
		ones = sel_s[3:0];
		tens = sel_s[7:4];
		unique case (program_select_coding)
			CODING_FIXED:
			begin
				dec_num = fixed_program_number;
				dec_bad = (fixed_program_number > PROG_MAX);
			end
			CODING_ONE_HOT_INPUTS:
			begin
				// lowest active input wins
				dec_bad = (sel_s == '0);
				for (int i = SEL_W - 1; i >= 0; i--)
					if (sel_s[i])
						dec_num = PROG_W'(i);
			end
			CODING_BINARY_INPUTS:
			begin
				dec_num = sel_s[PROG_W-1:0];
				dec_bad = (sel_s[PROG_W-1:0] > PROG_MAX);
			end
			CODING_BCD_INPUTS:
			begin
				dec_bad = (ones > 4'h9) || (tens > 4'h9);
				dec_num = PROG_W'({3'h0, tens} * 7'h0a + {3'h0, ones});
			end
		endcase
		launch_nxt = 1'b0;
		prog_nxt = prog_r;
		unav_nxt = unav_r;
		if (start_edge)
		begin
			prog_nxt = dec_num;
			unav_nxt = dec_bad || !programs_stored[dec_num[2:0]]
				&& (dec_num <= PROG_MAX);
			if (dec_num > PROG_MAX)
				unav_nxt = 1'b1;
			launch_nxt = !unav_nxt;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			launch_r <= 1'b0;
			prog_r <= DEFAULT_PROGRAM_ZERO;
			unav_r <= 1'b0;
		end
		else
		begin
			launch_r <= launch_nxt;
			prog_r <= prog_nxt;
			unav_r <= unav_nxt;
		end
	end
	assign program_launch = launch_r;
	assign program_number = prog_r;
	assign program_unavailable_error = unav_r;

	homing_gate_a: assert property ($rose(homing_active) |->
		$past(go_s) && $past(en_s))
		else $error("homing started without gate conditions");
	cam_only_a: assert property (homing_active && en_s &&
		control_holding && cam_found && !zero_search_enable |=> !homing_active)
		else $error("cam did not end homing");
	target_refuse_a: assert property (move_request && mon_en &&
		tgt_out |=> !move_accept && target_limit_error)
		else $error("out of range move accepted");
	limit_brake_a: assert property (mon_en && at_limit |=>
		brake_active && limit_reached_error)
		else $error("limit reached without braking");
	ramp_follow_a: assert property (##1 brake_ramp ==
		$past(limit_cfg.limit_braking_ramp))
		else $error("brake ramp not applied");
	zero_nomon_a: assert property (
		limit_cfg.positive_travel_limit == '0 &&
		limit_cfg.negative_travel_limit == '0 |=> !brake_active)
		else $error("monitoring with zero limits");
	homing_nomon_a: assert property (homing_active |=>
		!brake_active)
		else $error("monitoring during homing");
	fixed_prog_a: assert property (start_edge &&
		program_select_coding == CODING_FIXED |=>
		program_number == $past(fixed_program_number))
		else $error("fixed program not taken");
	bcd_bad_a: assert property (start_edge &&
		program_select_coding == CODING_BCD_INPUTS && sel_s[3:0] > 4'h9
		|=> program_unavailable_error && !program_launch)
		else $error("invalid bcd launched");
	launch_edge_a: assert property (program_launch |->
		$past(start_edge))
		else $error("launch without start edge");
endmodule : plps_top

// ==== verification/plps_term_model.sv ====
// terminal side model: program select lines and start pin
// assumes mclk from the bench; req is a one-cycle pulse
`timescale 1ns/10ps
module plps_term_model
(
	// clock and request
	input wire logic mclk,
	input wire logic req,
	input wire logic [7:0] sel,
	// pins
	output logic start_input,
	output logic [7:0] select_inputs
);
	logic slow = 1'b0;
	initial
	begin
		start_input = 1'b0;
		select_inputs = 8'h00;
	end
	always @(posedge mclk)
	begin
		if (req)
		begin
			select_inputs <= sel;
			slow <= ~slow;
			// lines settle first, fast and slow in turn
			repeat (slow ? 5 : 2) @(posedge mclk);
			start_input <= 1'b1;
			repeat (4) @(posedge mclk);
			start_input <= 1'b0;
		end
	end
endmodule : plps_term_model

// ==== verification/plps_bench.sv ====
// self-checking bench for plps_top against an integer model
// assumes plps_pkg and plps_term_model are compiled first
`timescale 1ns/10ps
module plps_bench;
	import plps_pkg::*;
	logic mclk = 0, reset = 1, en = 0, go = 0, hold = 0, cam = 0;
	logic mreq = 0, treq = 0, hm = 0, zse = 0, zp = 0, start;
	logic [7:0] tsel = 8'h00, stored = 8'hff, sel;
	logic [6:0] fixn = 7'h00, pn;
	logic signed [31:0] apos = 0, tpos = 0;
	plps_limit_cfg_type lim = '0;
	plps_home_vel_type hv = '0, hvo;
	plps_coding_type cod = CODING_FIXED;
	logic ha, hd, ma, te, le, ba, pl, pe;
	logic [15:0] br;
	int errors = 0, n_tests = 0, cyc = 0, seed = 32'h11d3_7601;
	always #2 mclk = ~mclk;
	plps_term_model u_plps_term_model (.mclk(mclk), .req(treq),
		.sel(tsel), .start_input(start), .select_inputs(sel));
	plps_top u_plps_top (.mclk(mclk), .reset(reset),
		.power_stage_enable_input(en), .go_input(go),
		.start_input(start), .select_inputs(sel), .control_holding(hold),
		.cam_found(cam), .zero_pulse(zp), .zero_search_enable(zse),
		.limit_cfg(lim), .home_vel_cfg(hv), .program_select_coding(cod),
		.fixed_program_number(fixn), .programs_stored(stored),
		.actual_position(apos), .target_position(tpos),
		.move_request(mreq), .homing_active(ha), .homing_done(hd),
		.homing_velocity(hvo), .move_accept(ma), .target_limit_error(te),
		.limit_reached_error(le), .brake_active(ba), .brake_ramp(br),
		.program_launch(pl), .program_number(pn),
		.program_unavailable_error(pe));
	task chk(input logic [95:0] s, input logic [95:0] e);
		n_tests++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task report_and_stop;
		$display("tests %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	function automatic logic [7:0] model(int c, logic [7:0] s, int f,
		logic [7:0] st);
		int n;
		logic e;
		n = f;
		e = 1'b0;
		if (c == 1)
		begin
			e = 1'b1;
			for (int b = 7; b >= 0; b--)
				if (s[b])
				begin
					n = b;
					e = 1'b0;
				end
		end
		if (c == 2)
			n = s[6:0];
		if (c == 3)
		begin
			n = s[7:4] * 10 + s[3:0];
			e = s[7:4] > 9 || s[3:0] > 9;
		end
		if (n > 99 || !st[n % 8])
			e = 1'b1;
		return {e, 7'(n)};
	endfunction : model
	task mv(input int t);
		logic r;
		@(posedge mclk);
		mreq <= 1'b1;
		tpos <= t;
		@(posedge mclk);
		mreq <= 1'b0;
		#1;
		r = (lim.positive_travel_limit != 0 || lim.negative_travel_limit != 0)
			&& !hm && (t > lim.positive_travel_limit
			|| t < lim.negative_travel_limit);
		chk({ma, te}, {!r, r});
	endtask : mv
	task pg(input int c, input logic [7:0] s);
		logic [7:0] m;
		int k;
		@(posedge mclk);
		cod <= plps_coding_type'(c);
		treq <= 1'b1;
		tsel <= s;
		@(posedge mclk);
		treq <= 1'b0;
		m = model(c, s, fixn, stored);
		k = 0;
		while (pl !== 1'b1 && k < 16)
		begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk(k < 16, !m[7]);
		if (!m[7])
			chk(pn, m[6:0]);
		@(posedge mclk);
		#1;
		chk(pe, m[7]);
		repeat (6) @(posedge mclk);
	endtask : pg
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			report_and_stop;
		end
	end
	initial
	begin
		repeat (4) @(posedge mclk);
		reset <= 1'b0;
		hv <= {$random(seed), $random(seed), $random(seed)};
		repeat (3) @(posedge mclk);
		pg(0, 8'h5a);
		chk(hvo, hv);
		lim <= {32'h0000_03e8, -32'sd1000, 16'($random(seed))};
		mv(1000);
		mv(-1001);
		repeat (8) mv($random(seed) % 2000);
		pg(3, 8'h9a);
		pg(1, 8'h00);
		for (int i = 0; i < 24; i++)
		begin
			fixn <= 7'($random(seed));
			stored <= i < 12 ? 8'hff : 8'($random(seed));
			pg(i % 4, 8'($random(seed)));
		end
		apos <= 2000;
		repeat (4) @(posedge mclk);
		#1;
		chk({le, ba, br}, {2'b11, lim.limit_braking_ramp});
		lim.positive_travel_limit <= 0;
		lim.negative_travel_limit <= 0;
		repeat (4) @(posedge mclk);
		#1;
		chk(le, 1'b0);
		mv(5000);
		lim.positive_travel_limit <= 1000;
		lim.negative_travel_limit <= -1000;
		apos <= 0;
		en <= 1'b1;
		hold <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk(ha, 1'b0);
		go <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk(ha, 1'b1);
		hm = 1'b1;
		go <= 1'b0;
		mv(5000);
		apos <= 3000;
		repeat (4) @(posedge mclk);
		#1;
		chk(le, 1'b0);
		cam <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk({ha, hd}, 2'b01);
		zse <= 1'b1;
		cam <= 1'b0;
		go <= 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		chk(ha, 1'b1);
		cam <= 1'b1;
		go <= 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		chk(ha, 1'b1);
		zp <= 1'b1;
		repeat (4) @(posedge mclk);
		#1;
		chk({ha, hd}, 2'b01);
		report_and_stop;
	end
endmodule : plps_bench
